// *** hw/pief_top.sv ***
// Peripheral interrupt enable and request-flag block with AHB-Lite slave
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "pief_defines.svh"

module pief_top
	import pief_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Peripheral event pulses
	input wire logic timer1_gate_evt,
	input wire logic converter_evt,
	input wire logic serial_transmit_evt,
	input wire logic timer2_match_evt,
	input wire logic timer1_overflow_evt,
	input wire logic comparator_evt,
	// Peripheral flag levels
	input wire logic serial_receive_level,
	input wire logic pwm_ch1_flag,
	input wire logic pwm_ch2_flag,
	input wire logic pwm_ch3_flag,
	// Requests
	output logic core_irq_req,
	output logic sys_irq
);

	localparam pief_state_t RST = '{
		ctl: `PIEF_REG_RST, pe1: `PIEF_REG_RST, pe2: `PIEF_REG_RST,
		pe3: `PIEF_REG_RST, pr1: `PIEF_REG_RST, pr2: `PIEF_REG_RST,
		pr3: `PIEF_REG_RST, st: `PIEF_REG_RST, mask: `PIEF_REG_RST,
		hrdata: 32'h00000000, hready: 1'b1, hresp: 1'b0, req: 1'b0,
		irq: 1'b0
	};

	pief_state_t s_r;
	pief_state_t s_nxt;
	logic rd_take;
	logic wr_take;
	logic [7:0] rd_addr;
	logic [7:0] wr_addr;
	logic [7:0] evt1;
	logic [7:0] evt2;
	logic [7:0] wd;
	logic [7:0] rsel;

	pief_ahb_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.rd_take(rd_take),
		.rd_addr(rd_addr),
		.wr_take(wr_take),
		.wr_addr(wr_addr)
	);

	assign wd = hwdata[7:0];

	always_comb begin
		s_nxt = s_r;
		evt1 = 8'h00;
		evt2 = 8'h00;
		rsel = 8'h00;
		evt1[`PIEF_T1G_BIT] = timer1_gate_evt;
		evt1[`PIEF_CONV_BIT] = converter_evt;
		evt1[`PIEF_TX_BIT] = serial_transmit_evt;
		evt1[`PIEF_T2_BIT] = timer2_match_evt;
		evt1[`PIEF_T1O_BIT] = timer1_overflow_evt;
		evt2[`PIEF_CMP_BIT] = comparator_evt;

		// Register writes; unmapped and status writes are dropped
		if (wr_take) begin
			if (wr_addr == `PIEF_OFS_CTL) begin
				s_nxt.ctl = wd & `PIEF_CTL_MASK;
			end else if (wr_addr == `PIEF_OFS_PE1) begin
				s_nxt.pe1 = wd & `PIEF_PE1_MASK;
			end else if (wr_addr == `PIEF_OFS_PE2) begin
				s_nxt.pe2 = wd & `PIEF_PE2_MASK;
			end else if (wr_addr == `PIEF_OFS_PE3) begin
				s_nxt.pe3 = wd & `PIEF_PE3_MASK;
			end else if (wr_addr == `PIEF_OFS_PR1) begin
				s_nxt.pr1 = wd & `PIEF_PR1_WMASK;
			end else if (wr_addr == `PIEF_OFS_PR2) begin
				s_nxt.pr2 = wd & `PIEF_PR2_MASK;
			end else if (wr_addr == `PIEF_OFS_MASK) begin
				s_nxt.mask = wd & `PIEF_ST_MASK;
			end
		end

		// Events win over a clearing write in the same cycle
		s_nxt.pr1 = s_nxt.pr1 | evt1;
		s_nxt.pr2 = s_nxt.pr2 | evt2;
		// Receive flag follows the receiver, cleared there by draining it
		s_nxt.pr1[`PIEF_RX_BIT] = serial_receive_level;
		s_nxt.pr3 = 8'h00;
		s_nxt.pr3[`PIEF_PWM1_BIT] = pwm_ch1_flag;
		s_nxt.pr3[`PIEF_PWM1_BIT + 1] = pwm_ch2_flag;
		s_nxt.pr3[`PIEF_PWM1_BIT + 2] = pwm_ch3_flag;

		s_nxt.req = s_nxt.ctl[`PIEF_GLB_EN_BIT]
			& s_nxt.ctl[`PIEF_GRP_EN_BIT]
			& (|((s_nxt.pr1 & s_nxt.pe1) | (s_nxt.pr2 & s_nxt.pe2)
			| (s_nxt.pr3 & s_nxt.pe3)));

		s_nxt.st[`PIEF_ST_REQ_BIT] = s_r.st[`PIEF_ST_REQ_BIT]
			| (s_nxt.req & ~s_r.req);
		s_nxt.st[`PIEF_ST_FLAG_BIT] = s_r.st[`PIEF_ST_FLAG_BIT]
			| (|evt1) | (|evt2);

		// Read data shows any write finishing in this same cycle
		if (rd_take) begin
			if (rd_addr == `PIEF_OFS_CTL) begin
				rsel = s_nxt.ctl;
			end else if (rd_addr == `PIEF_OFS_PE1) begin
				rsel = s_nxt.pe1;
			end else if (rd_addr == `PIEF_OFS_PE2) begin
				rsel = s_nxt.pe2;
			end else if (rd_addr == `PIEF_OFS_PE3) begin
				rsel = s_nxt.pe3;
			end else if (rd_addr == `PIEF_OFS_PR1) begin
				rsel = s_nxt.pr1;
			end else if (rd_addr == `PIEF_OFS_PR2) begin
				rsel = s_nxt.pr2;
			end else if (rd_addr == `PIEF_OFS_PR3) begin
				rsel = s_nxt.pr3;
			end else if (rd_addr == `PIEF_OFS_STAT) begin
				rsel = s_nxt.st;
				// Everything reported is cleared, so no event is lost
				s_nxt.st = 8'h00;
			end else if (rd_addr == `PIEF_OFS_MASK) begin
				rsel = s_nxt.mask;
			end
		end
		s_nxt.hrdata = {24'h000000, rsel};
		s_nxt.irq = |(s_nxt.st & s_nxt.mask);
		s_nxt.hready = 1'b1;
		// Never an error response, but still a flop output
		s_nxt.hresp = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.hready;
	assign hresp = s_r.hresp;
	assign core_irq_req = s_r.req;
	assign sys_irq = s_r.irq;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic wr_pe2;
	logic wr_pe3;
	logic wr_pr1;
	logic pend_any;
	assign wr_pe2 = wr_take && (wr_addr == `PIEF_OFS_PE2);
	assign wr_pe3 = wr_take && (wr_addr == `PIEF_OFS_PE3);
	assign wr_pr1 = wr_take && (wr_addr == `PIEF_OFS_PR1);
	assign pend_any = |((s_r.pr1 & s_r.pe1) | (s_r.pr2 & s_r.pe2)
		| (s_r.pr3 & s_r.pe3));

	logic wr_ctl;
	logic wr_pe1;
	logic wr_pr2;
	logic rd_stat;
	assign wr_ctl = wr_take && (wr_addr == `PIEF_OFS_CTL);
	assign wr_pe1 = wr_take && (wr_addr == `PIEF_OFS_PE1);
	assign wr_pr2 = wr_take && (wr_addr == `PIEF_OFS_PR2);
	assign rd_stat = rd_take && (rd_addr == `PIEF_OFS_STAT);

	a_cmp_enable_wr: assert property (
		wr_pe2 |=> s_r.pe2[`PIEF_CMP_BIT] == $past(hwdata[5]))
		else $error("comparator enable did not take write");

	a_pwm_enable_wr: assert property (
		wr_pe3 |=> s_r.pe3[6:4] == $past(hwdata[6:4]))
		else $error("pwm enables did not take write");

	a_group_blocks: assert property (
		!s_r.ctl[`PIEF_GRP_EN_BIT] |-> !core_irq_req)
		else $error("request without group enable");

	a_global_blocks: assert property (
		!s_r.ctl[`PIEF_GLB_EN_BIT] |-> !core_irq_req)
		else $error("request without global enable");

	a_req_forms: assert property (
		(s_r.ctl[7:6] == 2'b11 && pend_any) |-> core_irq_req)
		else $error("enabled pending source gave no request");

	a_rx_readonly: assert property (
		wr_pr1 |=> s_r.pr1[`PIEF_RX_BIT] == $past(serial_receive_level))
		else $error("receive flag changed by write");

	a_pwm_mirror: assert property (
		##1 s_r.pr3 == {1'b0, $past(pwm_ch3_flag), $past(pwm_ch2_flag),
		$past(pwm_ch1_flag), 4'h0})
		else $error("pwm pending does not mirror flags");

	a_evt_sets: assert property (
		(timer1_overflow_evt || comparator_evt) |=>
		(s_r.pr1[0] || !$past(timer1_overflow_evt))
		&& (s_r.pr2[5] || !$past(comparator_evt)))
		else $error("event did not set pending flag");

	a_unimpl_zero: assert property (
		hrdata[31:8] == 24'h0 && (s_r.pe1 & 8'h0C) == 8'h00
		&& (s_r.pr2 & 8'hDF) == 8'h00 && (s_r.pe3 & 8'h8F) == 8'h00)
		else $error("unimplemented bit set");

	a_irq_level: assert property (
		sys_irq == (|(s_r.st & s_r.mask)))
		else $error("interrupt output disagrees with status");

	// Write paths checked against fixed masks, not the design's defines
	a_ctl_write: assert property (
		wr_ctl |=> s_r.ctl == ($past(hwdata[7:0]) & 8'hC0))
		else $error("control write kept unimplemented bits");

	a_pe1_write: assert property (
		wr_pe1 |=> s_r.pe1 == ($past(hwdata[7:0]) & 8'hF3))
		else $error("enable one write wrong");

	a_pr1_write: assert property (
		wr_pr1 |=> (s_r.pr1 & 8'hD3)
		== (($past(hwdata[7:0]) & 8'hD3) | $past(evt1)))
		else $error("request one write wrong");

	a_pr2_write: assert property (
		wr_pr2 |=> s_r.pr2
		== (($past(hwdata[7:0]) & 8'h20) | $past(evt2)))
		else $error("comparator pending write wrong");

	a_flags_sticky: assert property (
		!wr_pr1 |=> ((s_r.pr1 & $past(s_r.pr1)) & 8'hD3)
		== ($past(s_r.pr1) & 8'hD3))
		else $error("pending flag dropped without a write");

	a_req_needs_pend: assert property (
		core_irq_req |-> (pend_any && s_r.ctl[7:6] == 2'h3))
		else $error("request without enabled pending source");

	// Read side: status clears, idle and unmapped reads return zero
	a_stat_clear: assert property (
		rd_stat |=> s_r.st == 8'h00)
		else $error("status not cleared by read");

	a_idle_hrdata: assert property (
		!rd_take |=> hrdata == 32'h00000000)
		else $error("read data without a read");

	a_unmapped_zero: assert property (
		(rd_take && rd_addr > `PIEF_OFS_MASK) |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");

	a_ctl_unimpl: assert property (
		(s_r.ctl & 8'h3F) == 8'h00 && (s_r.st & 8'hFC) == 8'h00
		&& (s_r.mask & 8'hFC) == 8'h00)
		else $error("unimplemented control or status bit set");

	a_bus_okay: assert property (
		hreadyout && !hresp)
		else $error("slave stalled or gave error response");

	c_req_rise: cover property ($rose(core_irq_req));
	c_irq_rise: cover property ($rose(sys_irq));
	c_pwm_req: cover property (core_irq_req && (|(s_r.pr3 & s_r.pe3)));
	c_cmp_clear_race: cover property (comparator_evt && wr_take
		&& wr_addr == `PIEF_OFS_PR2 && hwdata[5] == 1'b0);
	c_stat_race: cover property (rd_stat && ((|evt1) || (|evt2)));

endmodule

// *** hw/pief_defines.svh ***
// Register offsets, field positions, masks and reset values for pief
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

`define PIEF_OFS_CTL 8'h00
`define PIEF_OFS_PE1 8'h04
`define PIEF_OFS_PE2 8'h08
`define PIEF_OFS_PE3 8'h0C
`define PIEF_OFS_PR1 8'h10
`define PIEF_OFS_PR2 8'h14
`define PIEF_OFS_PR3 8'h18
`define PIEF_OFS_STAT 8'h1C
`define PIEF_OFS_MASK 8'h20

`define PIEF_GLB_EN_BIT 7
`define PIEF_GRP_EN_BIT 6
`define PIEF_T1G_BIT 7
`define PIEF_CONV_BIT 6
`define PIEF_RX_BIT 5
`define PIEF_TX_BIT 4
`define PIEF_T2_BIT 1
`define PIEF_T1O_BIT 0
`define PIEF_CMP_BIT 5
`define PIEF_PWM1_BIT 4
`define PIEF_ST_REQ_BIT 0
`define PIEF_ST_FLAG_BIT 1

`define PIEF_CTL_MASK 8'hC0
`define PIEF_PE1_MASK 8'hF3
`define PIEF_PE2_MASK 8'h20
`define PIEF_PE3_MASK 8'h70
`define PIEF_PR1_WMASK 8'hD3
`define PIEF_PR2_MASK 8'h20
`define PIEF_ST_MASK 8'h03

`define PIEF_REG_RST 8'h00
`define PIEF_HTRANS_NONSEQ_BIT 1

`endif

// *** hw/pief_pkg.sv ***
// Types shared by the pief register slave and core
package pief_pkg;

	typedef enum logic [1:0] {
		PIEF_PH_IDLE = 2'b01,
		PIEF_PH_WDATA = 2'b10
	} pief_phase_t;

	typedef struct packed {
		pief_phase_t phase;
		logic [7:0] waddr;
	} pief_slave_t;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] pe1;
		logic [7:0] pe2;
		logic [7:0] pe3;
		logic [7:0] pr1;
		logic [7:0] pr2;
		logic [7:0] pr3;
		logic [7:0] st;
		logic [7:0] mask;
		logic [31:0] hrdata;
		logic hready;
		logic hresp;
		logic req;
		logic irq;
	} pief_state_t;

endpackage

// *** hw/pief_ahb_slave.sv ***
// AHB-Lite address and data phase tracking for the pief registers
`timescale 1ns/1ns
`include "pief_defines.svh"

module pief_ahb_slave
	import pief_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Address phase
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	// Decoded accesses
	output logic rd_take,
	output logic [7:0] rd_addr,
	output logic wr_take,
	output logic [7:0] wr_addr
);

	pief_slave_t s_r;
	pief_slave_t s_nxt;
	logic valid;

	// Reads are answered from the address phase so the slave never waits
	assign valid = hsel & hready & htrans[`PIEF_HTRANS_NONSEQ_BIT];
	assign rd_take = valid & ~hwrite;
	assign rd_addr = haddr[7:0];
	assign wr_take = (s_r.phase == PIEF_PH_WDATA);
	assign wr_addr = s_r.waddr;

	always_comb begin
		s_nxt = s_r;
		case (s_r.phase)
			PIEF_PH_IDLE: begin
				if (valid && hwrite) begin
					s_nxt.phase = PIEF_PH_WDATA;
					s_nxt.waddr = haddr[7:0];
				end
			end
			PIEF_PH_WDATA: begin
				// Back-to-back write keeps the data phase armed
				if (valid && hwrite) begin
					s_nxt.waddr = haddr[7:0];
				end else begin
					s_nxt.phase = PIEF_PH_IDLE;
				end
			end
			default: begin
				s_nxt.phase = PIEF_PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{phase: PIEF_PH_IDLE, waddr: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

// *** testbench/pief_src_model.sv ***
// Peripheral event and flag source model driving the pief block
`timescale 1ns/1ns

module pief_src_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bench commands
	input wire logic [5:0] fire,
	input wire logic [3:0] lvl,
	// Event pulses and flag levels
	output logic [5:0] evt,
	output logic [3:0] flag
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt <= 6'h00;
			flag <= 4'h0;
		end else begin
			// Held command gives a strobe every other cycle
			evt <= fire & ~evt;
			// Flags are cleared only here, at the source
			flag <= lvl;
		end
	end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the pief interrupt enable and flag block
`timescale 1ns/1ns
`include "pief_defines.svh"
`define CHK(a, b) begin \
	tests_run++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("[ERR] %0t got %h want %h", $time, (a), (b)); \
	end \
end

module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [5:0] fire = 6'h00;
	logic [3:0] lvl = 4'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	logic hresp;
	logic core_irq_req;
	logic sys_irq;
	logic [5:0] evt;
	logic [3:0] flag;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	// Status and mask sit before the flags so no request is pending yet
	logic [7:0] ofs [9] = '{`PIEF_OFS_CTL, `PIEF_OFS_PE1, `PIEF_OFS_PE2,
		`PIEF_OFS_PE3, `PIEF_OFS_STAT, `PIEF_OFS_MASK, `PIEF_OFS_PR1,
		`PIEF_OFS_PR2, `PIEF_OFS_PR3};
	logic [7:0] wm [9] = '{8'hC0, 8'hF3, 8'h20, 8'h70, 8'h00, 8'h03,
		8'hD3, 8'h20, 8'h00};
	logic [7:0] eo [10] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
		8'h08, 8'h0C, 8'h0C, 8'h0C};
	logic [7:0] ev [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02, 8'h01,
		8'h20, 8'h40, 8'h20, 8'h10};

	always #10 hclk = ~hclk;

	pief_src_model u_src (.hclk(hclk), .hresetn(hresetn), .fire(fire),
		.lvl(lvl), .evt(evt), .flag(flag));

	pief_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.timer1_gate_evt(evt[5]), .converter_evt(evt[4]),
		.serial_transmit_evt(evt[3]), .timer2_match_evt(evt[2]),
		.timer1_overflow_evt(evt[1]), .comparator_evt(evt[0]),
		.serial_receive_level(flag[0]), .pwm_ch1_flag(flag[1]),
		.pwm_ch2_flag(flag[2]), .pwm_ch3_flag(flag[3]),
		.core_irq_req(core_irq_req), .sys_irq(sys_irq));

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		`CHK(rd, {24'h0, e})
	endtask

	task automatic req_chk(input logic e, input logic s);
		@(negedge hclk);
		`CHK(core_irq_req, e)
		`CHK(sys_irq, s)
		`CHK(hresp, 1'b0)
	endtask

	task automatic pulse(input logic [5:0] f);
		@(posedge hclk);
		fire <= f;
		@(posedge hclk);
		fire <= 6'h00;
		@(posedge hclk);
	endtask

	task automatic zero_chk();
		for (int i = 0; i < 9; i++) rd_chk(ofs[i], 8'h00);
		req_chk(1'b0, 1'b0);
	endtask

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		zero_chk();
		for (int i = 0; i < 9; i++) begin
			xfer(ofs[i], 1'b1, 8'hFF);
			rd_chk(ofs[i], wm[i]);
		end
		xfer(8'h24, 1'b1, 8'hFF);
		rd_chk(8'h24, 8'h00);
		req_chk(1'b1, 1'b1);
		rd_chk(`PIEF_OFS_STAT, 8'h01);
		req_chk(1'b1, 1'b0);
		// Stale flags go before any enable returns
		for (int i = 0; i < 9; i++) xfer(ofs[i], 1'b1, 8'h00);
		rd_chk(`PIEF_OFS_STAT, 8'h00);
		pulse(6'h3F);
		lvl <= 4'hF;
		rd_chk(`PIEF_OFS_PR1, 8'hF3);
		rd_chk(`PIEF_OFS_PR2, 8'h20);
		rd_chk(`PIEF_OFS_PR3, 8'h70);
		req_chk(1'b0, 1'b0);
		xfer(`PIEF_OFS_PE1, 1'b1, 8'hF3);
		xfer(`PIEF_OFS_CTL, 1'b1, 8'h80);
		req_chk(1'b0, 1'b0);
		xfer(`PIEF_OFS_CTL, 1'b1, 8'h40);
		req_chk(1'b0, 1'b0);
		xfer(`PIEF_OFS_PE1, 1'b1, 8'h00);
		xfer(`PIEF_OFS_CTL, 1'b1, 8'hC0);
		req_chk(1'b0, 1'b0);
		for (int i = 0; i < 10; i++) begin
			xfer(eo[i], 1'b1, ev[i]);
			req_chk(1'b1, 1'b0);
			xfer(eo[i], 1'b1, 8'h00);
			req_chk(1'b0, 1'b0);
		end
		xfer(`PIEF_OFS_MASK, 1'b1, 8'h01);
		req_chk(1'b0, 1'b1);
		rd_chk(`PIEF_OFS_STAT, 8'h03);
		xfer(`PIEF_OFS_MASK, 1'b1, 8'h02);
		req_chk(1'b0, 1'b0);
		pulse(6'h01);
		req_chk(1'b0, 1'b1);
		rd_chk(`PIEF_OFS_STAT, 8'h02);
		xfer(`PIEF_OFS_PR1, 1'b1, 8'h00);
		rd_chk(`PIEF_OFS_PR1, 8'h20);
		xfer(`PIEF_OFS_PR3, 1'b1, 8'h00);
		rd_chk(`PIEF_OFS_PR3, 8'h70);
		lvl <= 4'h0;
		pulse(6'h00);
		rd_chk(`PIEF_OFS_PR3, 8'h00);
		rd_chk(`PIEF_OFS_PR1, 8'h00);
		xfer(`PIEF_OFS_PE2, 1'b1, 8'h20);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		zero_chk();
		print_verdict();
	end
endmodule
